// *** pwmc_ctrl.sv ***
// pwm clock generators, channel enables and channel interrupt control behind ahb-lite
// Notes on behaviour
// - divide factor zero stops the derived clock
// - divide factor one passes prescaler output through
// - factors 2 to 255 divide prescaler output exactly
// - prescale code k up to 10 selects master clock over 2^k
// - enable write sets channel outputs for ones
// - disable write clears channel outputs for ones
// - state register shows which channels are enabled
// - irq enable write sets mask bits for ones
// - irq disable write clears mask bits for ones
// - masked period end raises interrupt until flags read, cleared through the flag clear register or masked off by irq disable write
// - reading period flags returns and clears them
//
// Design decisions made here: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "pwmc_map.svh"

module pwmc_ctrl (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // channel side
   input wire logic [3:0] period_end,
   output logic [3:0] channel_enabled,
   output logic derived_clock_a,
   output logic derived_clock_b,
   // interrupt
   output logic irq
);

   pwmc_pkg::pwmc_state_t st_r;
   pwmc_pkg::pwmc_state_t st_nxt;

   logic addr_ok;
   logic rd_req;
   logic pt_a;
   logic pt_b;
   logic [8:0] step_a;
   logic [8:0] step_b;
   logic [3:0] wdat;
   logic [3:0] isr_clr;
   // mode register fields of the two generators
   logic [7:0] div_a;
   logic [3:0] pre_a;
   logic [7:0] div_b;
   logic [3:0] pre_b;

   // one master clock cycle in 2^sel; reserved codes give no tick
   function automatic logic pre_tick(input logic [9:0] cnt, input logic [3:0] sel);
      logic [10:0] m;
      m = (11'h001 << sel) - 11'h001;
      if (sel > `PWMC_PRE_MAX) begin
         pre_tick = 1'b0;
      end else begin
         pre_tick = ((cnt & m[9:0]) == m[9:0]);
      end
   endfunction

   // returns {tick, next count} of one divider stage
   function automatic logic [8:0] div_step(input logic [7:0] cnt, input logic [7:0] div,
                                           input logic pt);
      div_step = {1'b0, cnt};
      if (div == 8'h00) begin
         div_step = 9'h000;
      end else if (div == 8'h01) begin
         div_step = {pt, 8'h00};
      end else if (pt) begin
         if (cnt >= div - 8'h01) begin
            div_step = {1'b1, 8'h00};
         end else begin
            div_step = {1'b0, cnt + 8'h01};
         end
      end
   endfunction

   assign addr_ok = (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'b00);
   assign rd_req = hsel && hready && htrans[1] && !hwrite;
   assign div_a = st_r.mr[`PWMC_DIV_A_LSB +: 8];
   assign pre_a = st_r.mr[`PWMC_PRE_A_LSB +: 4];
   assign div_b = st_r.mr[`PWMC_DIV_B_LSB +: 8];
   assign pre_b = st_r.mr[`PWMC_PRE_B_LSB +: 4];
   assign pt_a = pre_tick(st_r.pre_cnt, pre_a);
   assign pt_b = pre_tick(st_r.pre_cnt, pre_b);
   assign step_a = div_step(st_r.div_cnt_a, div_a, pt_a);
   assign step_b = div_step(st_r.div_cnt_b, div_b, pt_b);
   assign wdat = hwdata[3:0];

   always_comb begin
      st_nxt = st_r;
      isr_clr = 4'h0;
      st_nxt.pre_cnt = st_r.pre_cnt + 10'h001;
      st_nxt.div_cnt_a = step_a[7:0];
      st_nxt.tick_a = step_a[8];
      st_nxt.div_cnt_b = step_b[7:0];
      st_nxt.tick_b = step_b[8];
      // data phase of a write
      if (st_r.dph_wr) begin
         case (st_r.dph_addr)
            `PWMC_OFS_MR: st_nxt.mr = hwdata & `PWMC_MR_MASK;
            `PWMC_OFS_ENA: st_nxt.chan_en = st_r.chan_en | wdat;
            `PWMC_OFS_DIS: st_nxt.chan_en = st_r.chan_en & ~wdat;
            `PWMC_OFS_IER: st_nxt.imr = st_r.imr | wdat;
            `PWMC_OFS_IDR: st_nxt.imr = st_r.imr & ~wdat;
            `PWMC_OFS_ICR: isr_clr = wdat;
            default: ;
         endcase
      end
      // address phase: capture write target, or fetch read data
      st_nxt.dph_wr = hsel && hready && htrans[1] && hwrite && addr_ok;
      st_nxt.dph_addr = haddr[7:0];
      if (rd_req) begin
         st_nxt.rdata = 32'h0000_0000;
         if (addr_ok) begin
            case (haddr[7:0])
               // mode, state and mask reads already see a write in its data phase right ahead of them
               `PWMC_OFS_MR: st_nxt.rdata = st_nxt.mr;
               `PWMC_OFS_SR: st_nxt.rdata = {28'h000_0000, st_nxt.chan_en};
               `PWMC_OFS_IMR: st_nxt.rdata = {28'h000_0000, st_nxt.imr};
               `PWMC_OFS_ISR: begin
                  st_nxt.rdata = {28'h000_0000, st_r.isr};
                  isr_clr = 4'hF;
               end
               default: st_nxt.rdata = 32'h0000_0000;
            endcase
         end
      end
      // a period end in the clearing cycle is kept
      st_nxt.isr = (st_r.isr & ~isr_clr) | period_end;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= '{pre_cnt: 10'h000, div_cnt_a: 8'h00, div_cnt_b: 8'h00, tick_a: 1'b0,
                   tick_b: 1'b0, mr: `PWMC_MR_RST, chan_en: 4'h0, imr: 4'h0, isr: 4'h0,
                   dph_wr: 1'b0, dph_addr: 8'h00, rdata: 32'h0000_0000};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign hrdata = st_r.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign channel_enabled = st_r.chan_en;
   assign derived_clock_a = st_r.tick_a;
   assign derived_clock_b = st_r.tick_b;
   assign irq = |(st_r.isr & st_r.imr);

   // checks
   logic dwr_ena;
   logic dwr_dis;
   logic dwr_ier;
   logic dwr_idr;
   logic rd_isr;
   logic rd_sr;
   logic dwr_mr;
   logic dwr_icr;
   logic rd_wo;
   assign dwr_ena = st_r.dph_wr && (st_r.dph_addr == `PWMC_OFS_ENA);
   assign dwr_dis = st_r.dph_wr && (st_r.dph_addr == `PWMC_OFS_DIS);
   assign dwr_ier = st_r.dph_wr && (st_r.dph_addr == `PWMC_OFS_IER);
   assign dwr_idr = st_r.dph_wr && (st_r.dph_addr == `PWMC_OFS_IDR);
   assign rd_isr = rd_req && addr_ok && (haddr[7:0] == `PWMC_OFS_ISR);
   assign rd_sr = rd_req && addr_ok && (haddr[7:0] == `PWMC_OFS_SR);
   assign dwr_mr = st_r.dph_wr && (st_r.dph_addr == `PWMC_OFS_MR);
   assign dwr_icr = st_r.dph_wr && (st_r.dph_addr == `PWMC_OFS_ICR);
   assign rd_wo = rd_req && addr_ok && (haddr[7:0] == `PWMC_OFS_ENA);

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   property p_div_off;
      div_a == 8'h00 |=> !derived_clock_a;
   endproperty
   a_div_off: assert property (p_div_off) else $error("clock a ticks with factor zero");

   property p_div_one;
      (div_b == 8'h01) && pt_b |=> derived_clock_b;
   endproperty
   a_div_one: assert property (p_div_one) else $error("clock b misses prescaler tick");

   property p_div_n;
      (div_a >= 8'h02) && pt_a && (st_r.div_cnt_a == div_a - 8'h01)
         |=> derived_clock_a && (st_r.div_cnt_a == 8'h00);
   endproperty
   a_div_n: assert property (p_div_n) else $error("clock a divider wrong count");

   property p_div_gap;
      derived_clock_a && (div_a == 8'h02) && (pre_a == 4'h0)
         ##1 $stable(st_r.mr) |-> !derived_clock_a;
   endproperty
   a_div_gap: assert property (p_div_gap) else $error("divide by two ticks too often");

   property p_pre_full;
      ((pre_a == 4'h0) && (div_a == 8'h01)) [*2]
         |-> derived_clock_a;
   endproperty
   a_pre_full: assert property (p_pre_full) else $error("undivided clock a missing tick");

   property p_pre_rsv;
      pre_b > `PWMC_PRE_MAX |=> !derived_clock_b;
   endproperty
   a_pre_rsv: assert property (p_pre_rsv) else $error("reserved prescale gives ticks");

   property p_ena;
      dwr_ena |=> ((channel_enabled & $past(wdat)) == $past(wdat))
         && ((channel_enabled & ~$past(wdat)) == ($past(channel_enabled) & ~$past(wdat)));
   endproperty
   a_ena: assert property (p_ena) else $error("enable write wrong");

   property p_dis;
      dwr_dis |=> ((channel_enabled & $past(wdat)) == 4'h0)
         && ((channel_enabled & ~$past(wdat)) == ($past(channel_enabled) & ~$past(wdat)));
   endproperty
   a_dis: assert property (p_dis) else $error("disable write wrong");

   property p_sr;
      rd_sr |=> hrdata == {28'h000_0000, channel_enabled};
   endproperty
   a_sr: assert property (p_sr) else $error("state read mismatch");

   property p_ier;
      dwr_ier |=> (st_r.imr == ($past(st_r.imr) | $past(wdat)));
   endproperty
   a_ier: assert property (p_ier) else $error("irq enable write wrong");

   property p_idr;
      dwr_idr |=> (st_r.imr == ($past(st_r.imr) & ~$past(wdat)));
   endproperty
   a_idr: assert property (p_idr) else $error("irq disable write wrong");

   property p_irq_hold;
      irq && !rd_isr && !st_r.dph_wr |=> irq;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("irq dropped before flag read");

   property p_isr_rd;
      rd_isr |=> (hrdata[3:0] == $past(st_r.isr)) && (st_r.isr == $past(period_end));
   endproperty
   a_isr_rd: assert property (p_isr_rd) else $error("flag read did not clear");

   property p_mr_wr;
      dwr_mr |=> st_r.mr == ($past(hwdata) & `PWMC_MR_MASK);
   endproperty
   a_mr_wr: assert property (p_mr_wr) else $error("mode write not taken");

   property p_b_off;
      div_b == 8'h00 |=> !derived_clock_b;
   endproperty
   a_b_off: assert property (p_b_off) else $error("clock b ticks with factor zero");

   property p_b_div_n;
      (div_b >= 8'h02) && pt_b && (st_r.div_cnt_b == div_b - 8'h01)
         |=> derived_clock_b && (st_r.div_cnt_b == 8'h00);
   endproperty
   a_b_div_n: assert property (p_b_div_n) else $error("clock b divider wrong count");

   property p_a_rsv;
      pre_a > `PWMC_PRE_MAX |=> !derived_clock_a;
   endproperty
   a_a_rsv: assert property (p_a_rsv) else $error("reserved prescale gives ticks on a");

   property p_en_hold;
      !dwr_ena && !dwr_dis |=> $stable(channel_enabled);
   endproperty
   a_en_hold: assert property (p_en_hold) else $error("channel enables moved unasked");

   property p_imr_hold;
      !dwr_ier && !dwr_idr |=> $stable(st_r.imr);
   endproperty
   a_imr_hold: assert property (p_imr_hold) else $error("irq mask moved unasked");

   property p_irq_rise;
      ((period_end & st_r.imr) != 4'h0) && !dwr_idr |=> irq;
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("masked period end gave no irq");

   property p_icr;
      dwr_icr && !rd_isr
         |=> st_r.isr == (($past(st_r.isr) & ~$past(wdat)) | $past(period_end));
   endproperty
   a_icr: assert property (p_icr) else $error("flag clear write wrong");

   property p_wo_rd;
      rd_wo |=> hrdata == 32'h0000_0000;
   endproperty
   a_wo_rd: assert property (p_wo_rd) else $error("write-only register read not zero");

   c_irq: cover property (period_end != 4'h0 && st_r.imr != 4'h0 ##1 irq ##[1:20] rd_isr);
   c_div: cover property ((div_a == 8'h03) && derived_clock_a);
   c_ena: cover property (dwr_ena ##[1:10] dwr_dis);
   c_clr: cover property (dwr_icr && (st_r.isr != 4'h0));
   c_gap: cover property ((div_a == 8'h02) && (pre_a == 4'h0) && derived_clock_a);

endmodule
`default_nettype wire

// *** pwmc_map.svh ***
// register offsets, field positions and reset values of the pwm clock and channel control block
`ifndef PWMC_MAP_SVH
`define PWMC_MAP_SVH

`define PWMC_OFS_MR 8'h00
`define PWMC_OFS_ENA 8'h04
`define PWMC_OFS_DIS 8'h08
`define PWMC_OFS_SR 8'h0C
`define PWMC_OFS_IER 8'h10
`define PWMC_OFS_IDR 8'h14
`define PWMC_OFS_IMR 8'h18
`define PWMC_OFS_ISR 8'h1C
`define PWMC_OFS_ICR 8'h20

`define PWMC_DIV_A_LSB 0
`define PWMC_PRE_A_LSB 8
`define PWMC_DIV_B_LSB 16
`define PWMC_PRE_B_LSB 24
`define PWMC_MR_MASK 32'h0FFF_0FFF
`define PWMC_MR_RST 32'h0000_0000
`define PWMC_PRE_MAX 4'hA
`define PWMC_NCH 4

`endif

// *** pwmc_pkg.sv ***
// types of the pwm clock and channel control block
`default_nettype none
package pwmc_pkg;

   typedef struct packed {
      logic [9:0] pre_cnt;
      logic [7:0] div_cnt_a;
      logic [7:0] div_cnt_b;
      logic tick_a;
      logic tick_b;
      logic [31:0] mr;
      logic [3:0] chan_en;
      logic [3:0] imr;
      logic [3:0] isr;
      logic dph_wr;
      logic [7:0] dph_addr;
      logic [31:0] rdata;
   } pwmc_state_t;

endpackage
`default_nettype wire

// *** pwmc_tb.sv ***
// self-checking testbench of the pwm clock and channel control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'b010;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [3:0] pe = 4'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic dca;
   logic dcb;
   logic irq;
   logic [3:0] chen;
   logic [31:0] rd;
   int n_fail = 0;
   int num_checks = 0;

   always #5 hclk = ~hclk;

   pwmc_ctrl pwmc_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .period_end(pe),
      .channel_enabled(chen), .derived_clock_a(dca), .derived_clock_b(dcb), .irq(irq));

   task automatic tally_and_finish;
      if (n_fail == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one single word transfer; waits on hready in both phases
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
      htrans <= 2'b00;
      hwdata <= d;
      do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 100);
      rd = hrdata;
      chk("hresp", 32'h0000_0000, {31'h0, hresp});
      if (k >= 100) begin
         n_fail++;
         tally_and_finish();
      end
   endtask

   task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk(nm, e, rd);
   endtask

   task automatic pulse(input logic [3:0] m, input int wt);
      @(posedge hclk);
      pe <= m;
      @(posedge hclk);
      pe <= 4'h0;
      repeat (wt) @(posedge hclk);
      #1;
   endtask

   task automatic t_reset;
      rdc("mode", 32'h0000_0000, 32'h0000_0000);
      rdc("state", 32'h0000_000C, 32'h0000_0000);
      rdc("mask", 32'h0000_0018, 32'h0000_0000);
      rdc("flags", 32'h0000_001C, 32'h0000_0000);
      chk("irq", 32'h0, {31'h0, irq});
   endtask

   task automatic t_enable;
      bus(1'b1, 32'h0000_0004, 32'hFFFF_FFF5);
      rdc("state", 32'h0000_000C, 32'h0000_0005);
      chk("chen", 32'h5, {28'h0, chen});
      bus(1'b1, 32'h0000_0004, 32'h0000_0002);
      rdc("state", 32'h0000_000C, 32'h0000_0007);
      bus(1'b1, 32'h0000_0008, 32'hFFFF_FFF4);
      rdc("state", 32'h0000_000C, 32'h0000_0003);
      bus(1'b1, 32'h0000_0008, 32'h0000_0000);
      rdc("state", 32'h0000_000C, 32'h0000_0003);
      chk("chen", 32'h3, {28'h0, chen});
      bus(1'b1, 32'h0000_0040, 32'hFFFF_FFFF);
      rdc("unmapped", 32'h0000_0040, 32'h0000_0000);
      rdc("wo", 32'h0000_0004, 32'h0000_0000);
   endtask

   task automatic t_irq;
      bus(1'b1, 32'h0000_0010, 32'hFFFF_FFF3);
      rdc("mask", 32'h0000_0018, 32'h0000_0003);
      pulse(4'h5, 10);
      chk("irq", 32'h1, {31'h0, irq});
      rdc("flags", 32'h0000_001C, 32'h0000_0005);
      repeat (2) @(posedge hclk);
      #1;
      chk("irq", 32'h0, {31'h0, irq});
      rdc("flags", 32'h0000_001C, 32'h0000_0000);
      bus(1'b1, 32'h0000_0014, 32'h0000_0001);
      rdc("mask", 32'h0000_0018, 32'h0000_0002);
      pulse(4'h1, 2);
      chk("irq", 32'h0, {31'h0, irq});
      pulse(4'h2, 2);
      chk("irq", 32'h1, {31'h0, irq});
      rdc("flags", 32'h0000_001C, 32'h0000_0003);
   endtask

   // flag clear register drops only the flags written with ones
   task automatic t_clear;
      pulse(4'hF, 2);
      chk("irq", 32'h1, {31'h0, irq});
      bus(1'b1, 32'h0000_0020, 32'hFFFF_FFF6);
      #1;
      chk("irq", 32'h0, {31'h0, irq});
      rdc("flags", 32'h0000_001C, 32'h0000_0009);
   endtask

   // reset in mid-run brings every register back to zero
   task automatic t_rerun;
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      chk("chen", 32'h0, {28'h0, chen});
   endtask

   // each row: mode word, window, expected ticks of a and b in the window
   task automatic t_clk;
      logic [31:0] cf [6] = '{32'h0000_0000, 32'h0105_0203, 32'h0301_0001, 32'h0080_0A02,
         32'h0200_0B05, 32'h0402_0002};
      int wn [6] = '{120, 120, 120, 4096, 120, 128};
      int ea [6] = '{0, 10, 120, 2, 0, 64};
      int eb [6] = '{0, 12, 15, 32, 0, 4};
      int ca;
      int cb;
      bus(1'b1, 32'h0000_0000, 32'hFFFF_FFFF);
      rdc("mode", 32'h0000_0000, 32'h0FFF_0FFF);
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, 32'h0000_0000, cf[i]);
         rdc("mode", 32'h0000_0000, cf[i]);
         repeat (wn[i]) @(posedge hclk);
         ca = 0;
         cb = 0;
         repeat (wn[i]) begin
            @(posedge hclk);
            #1;
            ca += (dca !== 1'b0);
            cb += (dcb !== 1'b0);
         end
         chk("ticks_a", ea[i], ca);
         chk("ticks_b", eb[i], cb);
      end
   endtask

   initial begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_enable();
      t_irq();
      t_clear();
      t_clk();
      t_rerun();
      tally_and_finish();
   end
endmodule
`default_nettype wire
